// *** rtl/srw_pkg.sv ***
// Purpose: Shared constants for the supervisor reset watchdog block
// Assumes: 20 MHz core clock
// Notes: Times are kept in their own unit; cycle counts derive from them
package srw_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned RESET_PULSE_MS = 200;
  localparam int unsigned WDOG_TIMEOUT_MS = 1600;
  localparam int unsigned DEBOUNCE_US = 1000;
  // Longest time rounds down, least time rounds up; both are whole cycles here
  localparam int unsigned RESET_PULSE_CYC = (CLK_HZ / 1000) * RESET_PULSE_MS;
  localparam int unsigned WDOG_TIMEOUT_CYC = (CLK_HZ / 1000) * WDOG_TIMEOUT_MS;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000000) * DEBOUNCE_US;
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam int SYNC_W = 2;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 2'h3;
  typedef enum logic [1:0] {
    SRW_RST_HOLD = 2'b00,
    SRW_RST_WAIT = 2'b01,
    SRW_RST_RUN = 2'b10
  } srw_rst_state_t;
endpackage

// *** rtl/srw_sync_if.sv ***
// Purpose: Carries synchronised input levels between block modules
// Assumes: Single clock domain
// Notes: Sync module drives, core reads
`timescale 1ns/1ns
interface srw_sync_if;
  logic manualResetN;
  logic kick;
  logic supplyLow;
  logic powerFailLow;
  modport src (output manualResetN, output kick, output supplyLow, output powerFailLow);
  modport dst (input manualResetN, input kick, input supplyLow, input powerFailLow);
endinterface

// *** rtl/srw_input_sync.sv ***
// Purpose: Two-flop synchronisers for all asynchronous inputs
// Assumes: Inputs may change at any time
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
module srw_input_sync
  import srw_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Raw pins
  input wire logic manualResetN,
  input wire logic watchdogKick,
  input wire logic supplyLow,
  input wire logic powerFailSense,
  // Synchronised levels
  srw_sync_if.src syncOut
);
  logic [SYNC_W-1:0] mrSync_r;
  logic [SYNC_W-1:0] kickSync_r;
  logic [SYNC_W-1:0] lowSync_r;
  logic [SYNC_W-1:0] pfSync_r;

  // Manual reset and kick reset to their idle levels so no false event at release; supply-low resets high and power-fail sense resets low, both their fault levels
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mrSync_r <= SYNC_IDLE;
      kickSync_r <= '0;
      lowSync_r <= SYNC_IDLE;
      pfSync_r <= '0;
    end else begin
      mrSync_r <= {mrSync_r[0], manualResetN};
      kickSync_r <= {kickSync_r[0], watchdogKick};
      lowSync_r <= {lowSync_r[0], supplyLow};
      pfSync_r <= {pfSync_r[0], powerFailSense};
    end
  end

  assign syncOut.manualResetN = mrSync_r[1];
  assign syncOut.kick = kickSync_r[1];
  assign syncOut.supplyLow = lowSync_r[1];
  assign syncOut.powerFailLow = ~pfSync_r[1];
endmodule

// *** rtl/srw_supervisor.sv ***
// Purpose: Supervisor reset generator, watchdog and power-fail flag
// Assumes: Analog comparators outside; their results arrive as digital levels
// Notes: Single free-running clock; long counts are parameters for simulation
`timescale 1ns/1ns
module srw_supervisor
  import srw_pkg::*;
#(
  parameter logic [31:0] RESET_CYC = 32'(srw_pkg::RESET_PULSE_CYC),
  parameter logic [31:0] WDOG_CYC = 32'(srw_pkg::WDOG_TIMEOUT_CYC),
  parameter logic [31:0] DEBOUNCE_CYCLES = 32'(srw_pkg::DEBOUNCE_CYC)
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Comparator results
  input wire logic supply_low,
  input wire logic power_fail_sense,
  // Host-side pins
  input wire logic manual_reset_n,
  input wire logic watchdog_kick,
  // Outputs
  output logic reset_n,
  output logic reset_p,
  output logic power_fail_flag_n,
  output logic watchdog_expired_n
);
  import srw_pkg::*;

  srw_sync_if syncBus ();
  srw_rst_state_t state_r;
  srw_rst_state_t state_nxt;
  logic [CNT_W-1:0] rstCnt_r;
  logic [CNT_W-1:0] dbCnt_r;
  logic [CNT_W-1:0] wdCnt_r;
  logic mrClean_r;
  logic kickPrev_r;
  logic wdExpired_r;
  logic kickEdge;
  logic triggerHold;
  logic [CNT_W-1:0] chkFree_r;

  // Synchroniser stage; supply_low is expected as a comparator level
  srw_input_sync uSync (
    .core_clk(core_clk),
    .resetn(resetn),
    .manualResetN(manual_reset_n),
    .watchdogKick(watchdog_kick),
    .supplyLow(supply_low),
    .powerFailSense(power_fail_sense),
    .syncOut(syncBus.src)
  );

  // Debounce: the clean level follows the pin only after it stands still.
  // A floating pin is pulled high outside; reset value high treats it as idle.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dbCnt_r <= CNT_ZERO;
      mrClean_r <= 1'b1;
    end else if (syncBus.manualResetN == mrClean_r) begin
      dbCnt_r <= CNT_ZERO;
    end else if (dbCnt_r >= DEBOUNCE_CYCLES - CNT_ONE) begin
      dbCnt_r <= CNT_ZERO;
      mrClean_r <= syncBus.manualResetN;
    end else begin
      dbCnt_r <= dbCnt_r + CNT_ONE;
    end
  end

  // Causes that hold reset; the watchdog expiry is deliberately absent
  assign triggerHold = syncBus.supplyLow | ~mrClean_r;

  // Reset sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SRW_RST_HOLD: begin
        if (!triggerHold) begin
          state_nxt = SRW_RST_WAIT;
        end
      end
      SRW_RST_WAIT: begin
        if (triggerHold) begin
          state_nxt = SRW_RST_HOLD;
        end else if (rstCnt_r >= RESET_CYC - CNT_ONE) begin
          state_nxt = SRW_RST_RUN;
        end
      end
      SRW_RST_RUN: begin
        if (triggerHold) begin
          state_nxt = SRW_RST_HOLD;
        end
      end
      default: begin
        state_nxt = SRW_RST_HOLD;
      end
    endcase
  end

  // Sequencer state; starts in hold so power-up gives a full pulse
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SRW_RST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pulse counter; any new trigger restarts it from zero.
  // The entry cycle counts as zero, so release comes exactly RESET_CYC + 1 cycles after the causes clear.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstCnt_r <= CNT_ZERO;
    end else if (state_nxt != SRW_RST_WAIT || state_r != SRW_RST_WAIT) begin
      rstCnt_r <= CNT_ZERO;
    end else begin
      rstCnt_r <= rstCnt_r + CNT_ONE;
    end
  end

  // Reset outputs registered from the next state so both flip in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reset_n <= 1'b0;
      reset_p <= 1'b1;
    end else begin
      reset_n <= (state_nxt == SRW_RST_RUN);
      reset_p <= (state_nxt != SRW_RST_RUN);
    end
  end

  // Kick edge detection on the synchronised level
  // Both flops reset low, the host's idle kick level, so release shows no false edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      kickPrev_r <= 1'b0;
    end else begin
      kickPrev_r <= syncBus.kick;
    end
  end
  assign kickEdge = syncBus.kick ^ kickPrev_r;

  // Watchdog counter; expiry latches until the counter clears again
  // A kick on the last count clears first: it still came inside the timeout
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wdCnt_r <= CNT_ZERO;
      wdExpired_r <= 1'b0;
    end else if (state_r != SRW_RST_RUN || kickEdge) begin
      wdCnt_r <= CNT_ZERO;
      wdExpired_r <= 1'b0;
    end else if (wdCnt_r >= WDOG_CYC - CNT_ONE) begin
      wdExpired_r <= 1'b1;
    end else begin
      wdCnt_r <= wdCnt_r + CNT_ONE;
    end
  end

  // Expiry pin: low on timeout or supply low, bypassing the reset delay
  // Supply term comes from the synchroniser, not the sequencer, so recovery skips the pulse
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_expired_n <= 1'b0;
    end else begin
      watchdog_expired_n <= ~(wdExpired_r | syncBus.supplyLow);
    end
  end

  // Power-fail flag mirrors the comparator
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      power_fail_flag_n <= 1'b0;
    end else begin
      power_fail_flag_n <= ~syncBus.powerFailLow;
    end
  end

  // Checker helper: cycles since every cause cleared, counted apart from the sequencer.
  // It saturates at the pulse length so a long run never wraps into a false match.
  // Only the assertions read it; synthesis may drop it.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      chkFree_r <= CNT_ZERO;
    end else if (triggerHold) begin
      chkFree_r <= CNT_ZERO;
    end else if (chkFree_r != RESET_CYC) begin
      chkFree_r <= chkFree_r + CNT_ONE;
    end
  end

  // Watchdog timeout steps: last count with a silent host, then the latched expiry
  sequence seqWdLast;
    (wdCnt_r == WDOG_CYC - CNT_ONE) && !kickEdge && (state_r == SRW_RST_RUN);
  endsequence

  sequence seqWdLatched;
    wdExpired_r && !syncBus.supplyLow;
  endsequence

  // A cause returning during the delay sends the sequencer back to hold
  sequence seqRetrigger;
    (state_r == SRW_RST_WAIT) ##1 (state_r == SRW_RST_HOLD);
  endsequence

  // Assertions
  sequence seqCauseClear;
    !triggerHold && (state_r == SRW_RST_HOLD);
  endsequence

  AST_MR_RESET: assert property (@(posedge core_clk) disable iff (!resetn)
    !mrClean_r |=> !reset_n) else $error("Reset not asserted on manual reset");
  AST_RESET_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    syncBus.supplyLow |=> !reset_n) else $error("Reset released during supply low");
  AST_INVERSE: assert property (@(posedge core_clk) disable iff (!resetn)
    reset_p == !reset_n) else $error("Active-high reset not inverse");
  AST_PF_FLAG: assert property (@(posedge core_clk) disable iff (!resetn)
    power_fail_flag_n == !$past(syncBus.powerFailLow)) else $error("Power-fail flag wrong");
  AST_WDO_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
    syncBus.supplyLow |=> !watchdog_expired_n) else $error("Expiry not low in supply low");
  AST_WDO_REL: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(syncBus.supplyLow) && !wdExpired_r |=> watchdog_expired_n) else $error("Expiry release late");
  AST_WD_CLR: assert property (@(posedge core_clk) disable iff (!resetn)
    !reset_n && state_r != SRW_RST_RUN |=> wdCnt_r == CNT_ZERO) else $error("Watchdog not cleared");
  AST_WD_EDGE: assert property (@(posedge core_clk) disable iff (!resetn)
    kickEdge |=> wdCnt_r == CNT_ZERO && !wdExpired_r) else $error("Kick did not clear counter");
  AST_WD_STICK: assert property (@(posedge core_clk) disable iff (!resetn)
    wdExpired_r && !kickEdge && state_r == SRW_RST_RUN |=> wdExpired_r) else $error("Expiry dropped");
  AST_WD_FIRE: assert property (@(posedge core_clk) disable iff (!resetn)
    wdCnt_r == WDOG_CYC - CNT_ONE && !kickEdge && state_r == SRW_RST_RUN |=> wdExpired_r)
    else $error("Watchdog did not expire");
  AST_NO_WD_RESET: assert property (@(posedge core_clk) disable iff (!resetn)
    state_r == SRW_RST_RUN && !triggerHold |=> reset_n) else $error("Expiry caused reset");
  AST_START_WAIT: assert property (@(posedge core_clk) disable iff (!resetn)
    seqCauseClear |=> state_r == SRW_RST_WAIT && rstCnt_r == CNT_ZERO) else $error("Pulse timer not started");
  AST_RESTART: assert property (@(posedge core_clk) disable iff (!resetn)
    state_r == SRW_RST_WAIT && triggerHold |=> state_r == SRW_RST_HOLD && rstCnt_r == CNT_ZERO)
    else $error("Pulse timer not restarted");
  AST_PULSE_END: assert property (@(posedge core_clk) disable iff (!resetn)
    state_nxt == SRW_RST_RUN && state_r == SRW_RST_WAIT |-> rstCnt_r == RESET_CYC - CNT_ONE)
    else $error("Pulse length wrong");
  AST_DEBOUNCE: assert property (@(posedge core_clk) disable iff (!resetn)
    $changed(mrClean_r) |-> $past(dbCnt_r) == DEBOUNCE_CYCLES - CNT_ONE) else $error("Debounce bypassed");

  // Pulse length checked against the independent helper, not the sequencer counter
  AST_PULSE_LEN: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(reset_n) |-> $past(chkFree_r) == RESET_CYC)
    else $error("Reset released before the full pulse");
  AST_PULSE_DONE: assert property (@(posedge core_clk) disable iff (!resetn)
    chkFree_r == RESET_CYC && !triggerHold |=> reset_n)
    else $error("Reset held past the full pulse");
  AST_WAIT_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
    state_r == SRW_RST_WAIT |-> !reset_n && reset_p)
    else $error("Reset released during the delay");
  AST_RETRIG_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
    seqRetrigger |-> !reset_n && rstCnt_r == CNT_ZERO)
    else $error("Retrigger did not hold reset");
  AST_MR_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    !mrClean_r |=> state_r == SRW_RST_HOLD)
    else $error("Manual reset did not hold the sequencer");
  AST_SUPPLY_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    syncBus.supplyLow |=> state_r == SRW_RST_HOLD && rstCnt_r == CNT_ZERO)
    else $error("Supply low did not hold the sequencer");
  AST_RUN_ONLY: assert property (@(posedge core_clk) disable iff (!resetn)
    reset_n |-> state_r == SRW_RST_RUN)
    else $error("Reset released outside run");
  AST_INV_EDGE: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(reset_n) |-> $fell(reset_p))
    else $error("Active-high reset edge missing");
  AST_WD_PIN: assert property (@(posedge core_clk) disable iff (!resetn)
    seqWdLast ##1 seqWdLatched |=> !watchdog_expired_n)
    else $error("Expiry pin did not fall");
  AST_WD_LATCH: assert property (@(posedge core_clk) disable iff (!resetn)
    seqWdLatched |=> !watchdog_expired_n)
    else $error("Expiry pin rose while latched");
  AST_WD_QUIET: assert property (@(posedge core_clk) disable iff (!resetn)
    !wdExpired_r && !syncBus.supplyLow |=> watchdog_expired_n)
    else $error("Expiry pin low without cause");
  AST_WD_RSTCLR: assert property (@(posedge core_clk) disable iff (!resetn)
    state_r != SRW_RST_RUN |=> !wdExpired_r)
    else $error("Expiry survived reset");
  AST_WD_RANGE: assert property (@(posedge core_clk) disable iff (!resetn)
    wdCnt_r <= WDOG_CYC - CNT_ONE)
    else $error("Watchdog counter overran");
  AST_DB_STEADY: assert property (@(posedge core_clk) disable iff (!resetn)
    syncBus.manualResetN == mrClean_r |=> $stable(mrClean_r) && dbCnt_r == CNT_ZERO)
    else $error("Debounce moved on a steady pin");
endmodule

// *** dv/srw_host_model.sv ***
// Purpose: Host processor stand-in that services the watchdog kick pin
// Assumes: Same clock as the supervisor; PERIOD below the watchdog timeout
// Notes: Host stalls while held in reset, as a real processor would
`timescale 1ns/1ns
module srw_host_model #(
  parameter int PERIOD = 20
) (
  // Clock
  input wire logic core_clk,
  // Device output seen by the host
  input wire logic resetN,
  // Bench control; low models hung firmware
  input wire logic kickEnable,
  // Host pin
  output logic watchdogKick
);
  int cnt = 0;
  initial watchdogKick = 1'b0;
  // Toggle once per PERIOD; a slow PERIOD lets the bench provoke expiry
  always @(posedge core_clk) begin
    if (kickEnable && resetN) begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      if (cnt == PERIOD - 1) watchdogKick <= ~watchdogKick;
    end
  end
endmodule

// *** dv/tb.sv ***
// Purpose: Self-checking bench for the supervisor reset watchdog
// Assumes: Shortened counts RESET_CYC 20, WDOG_CYC 50, DEBOUNCE_CYCLES 4
// Notes: Checks are queued as notes; a monitor process compares them
`timescale 1ns/1ns
module tb;
  import srw_pkg::*;
  localparam int RC = 32'h14;
  localparam int WC = 32'h32;
  typedef struct {string name; int sel; logic exp;} srw_note_t;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic supplyLow = 1'b0;
  logic powerFailSense = 1'b1;
  logic manualResetN = 1'b1; // Idle high, as an open pin reads
  logic kickEn = 1'b0;
  wire logic watchdogKick;
  wire logic resetN, resetP, powerFailFlagN, watchdogExpiredN;
  int n_errors = 0;
  int checked = 0;
  int seed = 41;
  int len;
  srw_note_t notes[$];
  event noteEv;

  // 50 ns period
  always #25 core_clk = ~core_clk;

  srw_supervisor #(.RESET_CYC(32'h14), .WDOG_CYC(32'h32), .DEBOUNCE_CYCLES(32'h4)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .supply_low(supplyLow), .power_fail_sense(powerFailSense),
    .manual_reset_n(manualResetN), .watchdog_kick(watchdogKick), .reset_n(resetN), .reset_p(resetP),
    .power_fail_flag_n(powerFailFlagN), .watchdog_expired_n(watchdogExpiredN));

  srw_host_model #(.PERIOD(20)) u_host (
    .core_clk(core_clk), .resetN(resetN), .kickEnable(kickEn), .watchdogKick(watchdogKick));

  function automatic logic pick(int s);
    case (s)
      0: return resetN;
      1: return resetP;
      2: return powerFailFlagN;
      default: return watchdogExpiredN;
    endcase
  endfunction

  // Monitor: takes the oldest note and compares it with the settled output
  always @(noteEv) begin
    srw_note_t n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      checked++;
      if (pick(n.sel) !== n.exp) begin
        n_errors++;
        $display("unexpected %s: expected %b, seen %b", n.name, n.exp, pick(n.sel));
      end
    end
  end

  task automatic check(string nm, int s, logic e);
    notes.push_back('{nm, s, e});
    ->noteEv;
    #1;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Bounded wait; the following check reports a miss
  task automatic wait_lvl(int s, logic v, int lim);
    int n = 0;
    while (pick(s) !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic print_verdict();
    $display("counts: checked %0d, n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog on the bench itself: tests need about 600 cycles
  initial begin
    #(50 * 6000);
    n_errors++;
    $display("unexpected timeout: expected finish, seen hang");
    print_verdict();
  end

  initial begin
    cyc(10);
    @(posedge core_clk) resetn <= 1'b1;
    cyc(RC - 2);
    check("reset_n", 0, 1'b0);
    check("reset_p", 1, 1'b1);
    // Release lands RC + 1 cycles after the synchronised supply-low clears, two edges after reset
    cyc(4);
    check("reset_n", 0, 1'b0);
    cyc(1);
    check("reset_n", 0, 1'b1);
    check("reset_p", 1, 1'b0);
    $display("test power-on pulse done");
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk) powerFailSense <= 1'($random(seed));
      cyc(4);
      check("power_fail_flag_n", 2, powerFailSense);
    end
    $display("test power-fail flag done");
    @(posedge core_clk) kickEn <= 1'b1;
    cyc(3 * WC);
    check("watchdog_expired_n", 3, 1'b1);
    @(posedge core_clk) kickEn <= 1'b0;
    wait_lvl(3, 1'b0, WC + 10);
    check("watchdog_expired_n", 3, 1'b0);
    cyc(WC);
    check("watchdog_expired_n", 3, 1'b0);
    check("reset_n", 0, 1'b1);
    @(posedge core_clk) kickEn <= 1'b1;
    wait_lvl(3, 1'b1, 30);
    check("watchdog_expired_n", 3, 1'b1);
    $display("test watchdog done");
    // Switch bounce: lows shorter than the debounce span
    for (int i = 0; i < 6; i++) begin
      len = 1 + (($random(seed) & 32'h7FFF_FFFF) % 3);
      @(posedge core_clk) manualResetN <= 1'b0;
      cyc(len - 1);
      @(posedge core_clk) manualResetN <= 1'b1;
      cyc(6);
      check("reset_n", 0, 1'b1);
    end
    @(posedge core_clk) manualResetN <= 1'b0;
    wait_lvl(0, 1'b0, 12);
    check("reset_n", 0, 1'b0);
    cyc(4);
    @(posedge core_clk) manualResetN <= 1'b1;
    cyc(RC - 2);
    check("reset_n", 0, 1'b0);
    wait_lvl(0, 1'b1, 16);
    check("reset_n", 0, 1'b1);
    $display("test manual reset done");
    @(posedge core_clk) begin
      supplyLow <= 1'b1;
      kickEn <= 1'b0;
    end
    wait_lvl(0, 1'b0, 5);
    check("reset_n", 0, 1'b0);
    check("watchdog_expired_n", 3, 1'b0);
    cyc(30);
    check("reset_n", 0, 1'b0);
    @(posedge core_clk) supplyLow <= 1'b0;
    cyc(4);
    check("watchdog_expired_n", 3, 1'b1);
    check("reset_n", 0, 1'b0);
    cyc(8);
    @(posedge core_clk) supplyLow <= 1'b1;
    cyc(3);
    @(posedge core_clk) supplyLow <= 1'b0;
    cyc(RC - 2);
    check("reset_n", 0, 1'b0);
    wait_lvl(0, 1'b1, 10);
    check("reset_n", 0, 1'b1);
    // No kicks since the dip: a counter not held clear would expire early
    cyc(WC - 5);
    check("watchdog_expired_n", 3, 1'b1);
    wait_lvl(3, 1'b0, 15);
    check("watchdog_expired_n", 3, 1'b0);
    $display("test supply dip done");
    print_verdict();
  end
endmodule
